// File: fci_host.sv
// host controller for a boot-block flash command interface, reached over apb.
// assumes the flash sits directly on the pins below and that software orders one
// operation at a time through the control register.
//
// Behaviour
// - every unlocked instruction starts with AAh to 5555h then 55h to 2AAAh.
// - after a reset given during program or erase, wait the recovery time.
// - signature read is unlock then 90h to 5555h; reads then return identity codes.
// - program is unlock, A0h to 5555h, then target address and data.
// - block erase is unlock, 80h to 5555h, unlock, then 30h at block address.
// - extra 30h confirms need no unlock, must beat the timeout, and restart it.
// - chip erase is unlock, 80h to 5555h, unlock, then 10h to 5555h.
// - B0h suspends a block erase; a later 30h write resumes it.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module fci_host
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flash_select_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] flash_addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i,
  output logic flash_reset_n,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {SQ_IDLE, SQ_STEP, SQ_WAIT, SQ_POLL, SQ_RECOVER} fci_sq_state_t;
  typedef enum logic [1:0] {PH_STEP, PH_POLL_A, PH_POLL_B, PH_CHECK} fci_phase_t;

  typedef struct packed {
    fci_sq_state_t st;
    fci_phase_t ph;
    logic [3:0] op;
    logic [3:0] step;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic tog;
    logic err_seen;
    logic need_rec;
    logic busy;
    logic done;
    logic fail;
    logic late;
    logic reject;
    logic req;
    logic req_wr;
    logic [19:0] req_addr;
    logic [7:0] req_data;
    logic [15:0] rec_cnt;
    logic rst_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fci_host_t;

  fci_host_t s_reg;
  fci_host_t s_next;
  fci_pkg::fci_step_t cur;

  fci_cyc_if cyc ();

  // ==========================================================================
  // instruction sequences
  // ==========================================================================
  // one table entry per bus cycle; an erase is issued as whole sequences only, because
  // any deviation throws the flash back to read-array
  function automatic fci_pkg::fci_step_t step_of
  (
    input logic [3:0] op,
    input logic [3:0] n,
    input logic [19:0] a,
    input logic [7:0] d
  );
    fci_pkg::fci_step_t s;
    logic [3:0] u;
    s.kind = fci_pkg::CYC_END;
    s.addr = a;
    s.data = d;
    // erase sequences repeat the coded pair on cycles four and five
    u = ((op == fci_pkg::OP_BLOCK_ERASE) || (op == fci_pkg::OP_CHIP_ERASE)) && (n >= 4'h3) ?
        n - 4'h3 : n;
    // unlock prefix, never sent for single-cycle commands
    if ((op == fci_pkg::OP_SIGNATURE) || (op == fci_pkg::OP_PROGRAM) ||
        (op == fci_pkg::OP_BLOCK_ERASE) || (op == fci_pkg::OP_CHIP_ERASE))
    begin
      if (u == 4'h0)
      begin
        s.kind = fci_pkg::CYC_WR;
        s.addr = fci_pkg::UNLOCK_ADDR1;
        s.data = fci_pkg::UNLOCK_DATA1;
      end
      else if (u == 4'h1)
      begin
        s.kind = fci_pkg::CYC_WR;
        s.addr = fci_pkg::UNLOCK_ADDR2;
        s.data = fci_pkg::UNLOCK_DATA2;
      end
    end
    unique case (op)
      fci_pkg::OP_RESET:
        if (n == 4'h0)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.data = fci_pkg::CMD_READ_RESET;
        end
      fci_pkg::OP_SIGNATURE:
        if (n == 4'h2)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.addr = fci_pkg::UNLOCK_ADDR1;
          s.data = fci_pkg::CMD_SIGNATURE;
        end
        else if (n == 4'h3)
          s.kind = fci_pkg::CYC_RD;
      fci_pkg::OP_READ:
        if (n == 4'h0)
          s.kind = fci_pkg::CYC_RD;
      fci_pkg::OP_PROGRAM:
        if (n == 4'h2)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.addr = fci_pkg::UNLOCK_ADDR1;
          s.data = fci_pkg::CMD_PROGRAM;
        end
        else if (n == 4'h3)
          s.kind = fci_pkg::CYC_WR;
        else if (n == 4'h4)
          s.kind = fci_pkg::CYC_POLL;
      fci_pkg::OP_BLOCK_ERASE, fci_pkg::OP_CHIP_ERASE:
        if (n == 4'h2)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.addr = fci_pkg::UNLOCK_ADDR1;
          s.data = fci_pkg::CMD_ERASE_SETUP;
        end
        else if (n == 4'h5 && op == fci_pkg::OP_BLOCK_ERASE)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.data = fci_pkg::CMD_BLOCK_CONFIRM;
        end
        else if (n == 4'h5)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.addr = fci_pkg::UNLOCK_ADDR1;
          s.data = fci_pkg::CMD_CHIP_CONFIRM;
        end
        else if (n == 4'h6 && op == fci_pkg::OP_CHIP_ERASE)
          s.kind = fci_pkg::CYC_POLL;
      fci_pkg::OP_ADD_BLOCK:
        if (n == 4'h0)
          s.kind = fci_pkg::CYC_CHK;
        else if (n == 4'h1)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.data = fci_pkg::CMD_BLOCK_CONFIRM;
        end
      fci_pkg::OP_SUSPEND:
        if (n == 4'h0)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.data = fci_pkg::CMD_SUSPEND;
        end
        else if (n == 4'h1)
          s.kind = fci_pkg::CYC_POLL;
      fci_pkg::OP_RESUME:
        if (n == 4'h0)
        begin
          s.kind = fci_pkg::CYC_WR;
          s.data = fci_pkg::CMD_BLOCK_CONFIRM;
        end
      fci_pkg::OP_WAIT:
        if (n == 4'h0)
          s.kind = fci_pkg::CYC_POLL;
      default:
        s.kind = fci_pkg::CYC_BAD;
    endcase
    return s;
  endfunction

  assign cur = step_of(s_reg.op, s_reg.step, s_reg.addr, s_reg.wdata);

  // ==========================================================================
  // sequencer and register file
  // ==========================================================================
  always_comb
  begin
    s_next = s_reg;
    s_next.req = 1'b0;
    // apb: act at the edge that samples pready, answer one cycle after the access starts
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (psel && penable && !s_reg.pready)
    begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h0000_0000;
      unique case (paddr)
        fci_pkg::REG_CTRL:
          s_next.prdata = {28'h000_0000, s_reg.op};
        fci_pkg::REG_ADDR:
          s_next.prdata = {12'h000, s_reg.addr};
        fci_pkg::REG_WDATA:
          s_next.prdata = {24'h00_0000, s_reg.wdata};
        fci_pkg::REG_STATUS:
        begin
          s_next.prdata[fci_pkg::ST_BUSY] = s_reg.busy;
          s_next.prdata[fci_pkg::ST_DONE] = s_reg.done;
          s_next.prdata[fci_pkg::ST_FAIL] = s_reg.fail;
          s_next.prdata[fci_pkg::ST_LATE] = s_reg.late;
          s_next.prdata[fci_pkg::ST_RDY] = ready_busy_n;
          s_next.prdata[fci_pkg::ST_REJECT] = s_reg.reject;
          s_next.prdata[fci_pkg::ST_RDATA_LSB +: 8] = s_reg.rdata;
        end
        fci_pkg::REG_PIN:
          s_next.prdata = {31'h000_0000, s_reg.rst_n};
        default:
          s_next.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_reg.pready && pwrite)
    begin
      if (paddr == fci_pkg::REG_ADDR && !s_reg.busy)
        s_next.addr = pwdata[19:0];
      if (paddr == fci_pkg::REG_WDATA && !s_reg.busy)
        s_next.wdata = pwdata[7:0];
      if (paddr == fci_pkg::REG_PIN)
        s_next.rst_n = pwdata[0];
      if (paddr == fci_pkg::REG_CTRL && s_reg.busy)
        s_next.reject = 1'b1; // one operation at a time
      else if (paddr == fci_pkg::REG_CTRL)
      begin
        s_next.op = pwdata[3:0];
        s_next.step = 4'h0;
        s_next.busy = 1'b1;
        s_next.done = 1'b0;
        s_next.fail = 1'b0;
        s_next.late = 1'b0;
        s_next.reject = 1'b0;
        s_next.err_seen = 1'b0;
        s_next.need_rec = ~ready_busy_n; // reset over a running operation
        s_next.st = SQ_STEP;
      end
    end

    // command sequencer
    unique case (s_reg.st)
      SQ_IDLE:
      begin
      end
      SQ_STEP:
      begin
        s_next.ph = PH_STEP;
        s_next.req_addr = cur.addr;
        s_next.req_data = cur.data;
        unique case (cur.kind)
          fci_pkg::CYC_WR, fci_pkg::CYC_RD, fci_pkg::CYC_CHK:
          begin
            s_next.req = 1'b1;
            s_next.req_wr = (cur.kind == fci_pkg::CYC_WR);
            s_next.ph = (cur.kind == fci_pkg::CYC_CHK) ? PH_CHECK : PH_STEP;
            s_next.st = SQ_WAIT;
          end
          fci_pkg::CYC_POLL:
            s_next.st = SQ_POLL;
          fci_pkg::CYC_END:
          begin
            // a reset given over a running operation needs the recovery wait
            if (s_reg.op == fci_pkg::OP_RESET && s_reg.need_rec)
            begin
              s_next.st = SQ_RECOVER;
              s_next.rec_cnt = 16'(fci_pkg::RECOVERY_CYC);
            end
            else
            begin
              s_next.st = SQ_IDLE;
              s_next.busy = 1'b0;
              s_next.done = 1'b1;
            end
          end
          default:
          begin
            s_next.st = SQ_IDLE;
            s_next.busy = 1'b0;
            s_next.fail = 1'b1;
          end
        endcase
      end
      SQ_POLL:
      begin
        // two back-to-back status reads; a steady toggle bit means finished
        s_next.req = 1'b1;
        s_next.req_wr = 1'b0;
        s_next.req_addr = s_reg.addr;
        s_next.ph = PH_POLL_A;
        s_next.st = SQ_WAIT;
      end
      SQ_WAIT:
        if (cyc.done)
        begin
          unique case (s_reg.ph)
            PH_STEP:
            begin
              if (!s_reg.req_wr)
                s_next.rdata = cyc.rdata;
              s_next.step = s_reg.step + 4'h1;
              s_next.st = SQ_STEP;
            end
            PH_CHECK:
              if (cyc.rdata[fci_pkg::ERASE_TIMER_BIT])
              begin
                // timeout gone: a late confirm would be taken as a new command
                s_next.late = 1'b1;
                s_next.fail = 1'b1;
                s_next.busy = 1'b0;
                s_next.st = SQ_IDLE;
              end
              else
              begin
                s_next.step = s_reg.step + 4'h1;
                s_next.st = SQ_STEP;
              end
            PH_POLL_A:
            begin
              s_next.tog = cyc.rdata[fci_pkg::TOGGLE_BIT];
              s_next.req = 1'b1;
              s_next.ph = PH_POLL_B;
            end
            PH_POLL_B:
            begin
              s_next.rdata = cyc.rdata;
              if (cyc.rdata[fci_pkg::TOGGLE_BIT] == s_reg.tog)
              begin
                s_next.step = s_reg.step + 4'h1;
                s_next.st = SQ_STEP;
              end
              else if (s_reg.err_seen)
              begin
                // still toggling after the error bit: failed, return flash to read-array
                s_next.fail = 1'b1;
                s_next.op = fci_pkg::OP_RESET;
                s_next.step = 4'h0;
                s_next.need_rec = 1'b1;
                s_next.st = SQ_STEP;
              end
              else
              begin
                s_next.err_seen = cyc.rdata[fci_pkg::ERROR_BIT];
                s_next.st = SQ_POLL;
              end
            end
          endcase
        end
      SQ_RECOVER:
        if (s_reg.rec_cnt <= 16'h0001)
        begin
          s_next.st = SQ_IDLE;
          s_next.busy = 1'b0;
          s_next.done = ~s_reg.fail;
        end
        else
          s_next.rec_cnt = s_reg.rec_cnt - 16'h0001;
    endcase
  end

  // state register; the flash reset pin comes out of reset released, then follows bit 0 written to REG_PIN
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '{st: SQ_IDLE, ph: PH_STEP, op: 4'h0, step: 4'h0, addr: 20'h0_0000,
                 wdata: 8'h00, rdata: 8'h00, tog: 1'b0, err_seen: 1'b0, need_rec: 1'b0,
                 busy: 1'b0, done: 1'b0, fail: 1'b0, late: 1'b0, reject: 1'b0, req: 1'b0,
                 req_wr: 1'b0, req_addr: 20'h0_0000, req_data: 8'h00, rec_cnt: 16'h0000,
                 rst_n: 1'b1, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
    else
      s_reg <= s_next;
  end

  assign cyc.req = s_reg.req;
  assign cyc.wr = s_reg.req_wr;
  assign cyc.addr = s_reg.req_addr;
  assign cyc.wdata = s_reg.req_data;
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign flash_reset_n = s_reg.rst_n;

  // ==========================================================================
  // pin cycle engine
  // ==========================================================================
  // every flash pin but flash_reset_n comes from the engine's own flip-flops
  fci_bus_engine u_engine
  (
    .clk(clk),
    .arst_n(arst_n),
    .cyc(cyc.eng),
    .flash_select_n(flash_select_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .addr(flash_addr),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i)
  );

endmodule // fci_host

// File: fci_pkg.sv
// package of the flash command interface host controller: register map, field positions,
// flash instruction codes, coded-cycle addresses and timing counts.
// assumes a 20 mhz clock and a flash part with a byte-wide asynchronous bus.
package fci_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_STROBE_NS = 100; // least low time of write or output strobe
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RECOVERY_NS = 30000; // wait after a reset given during an operation
  localparam int RECOVERY_CYC = (T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // register map (byte addresses of aligned words)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_PIN = 8'h10;

  // status word fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_LATE = 3;
  localparam int ST_RDY = 4;
  localparam int ST_REJECT = 5;
  localparam int ST_RDATA_LSB = 8;

  // ==========================================================================
  // flash codes and coded-cycle addresses
  // ==========================================================================
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h0_5555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h0_2aaa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_READ_RESET = 8'hf0;
  localparam logic [7:0] CMD_SIGNATURE = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;

  // status bit positions on the data lines
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT = 5;
  localparam int ERASE_TIMER_BIT = 3;

  // ==========================================================================
  // operations ordered through the control register
  // ==========================================================================
  localparam logic [3:0] OP_RESET = 4'h0;
  localparam logic [3:0] OP_SIGNATURE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_BLOCK_ERASE = 4'h4;
  localparam logic [3:0] OP_ADD_BLOCK = 4'h5;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_WAIT = 4'h9;

  typedef enum logic [2:0] {CYC_WR, CYC_RD, CYC_CHK, CYC_POLL, CYC_END, CYC_BAD} fci_cyc_t;

  typedef struct packed {
    fci_cyc_t kind;
    logic [19:0] addr;
    logic [7:0] data;
  } fci_step_t;

endpackage

// File: fci_cyc_if.sv
// interface between the command sequencer and the bus cycle engine.
// assumes both ends run on the same clock; req is a one-cycle pulse, done too.
`timescale 1ns/1ps
interface fci_cyc_if;
  logic req;
  logic wr;
  logic [19:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// File: fci_bus_engine.sv
// bus cycle engine: turns one request into one asynchronous read or write cycle on the
// flash pins. assumes the requester waits for done before the next request.
`timescale 1ns/1ps
module fci_bus_engine
(
  input wire logic clk,
  input wire logic arst_n,
  fci_cyc_if.eng cyc,
  output logic flash_select_n,
  output logic oe_n,
  output logic we_n,
  output logic [19:0] addr,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_i
);

  typedef enum logic [1:0] {EN_IDLE, EN_SETUP, EN_STROBE, EN_HOLD} fci_en_state_t;

  typedef struct packed {
    fci_en_state_t st;
    logic wr;
    logic [3:0] cnt;
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic [19:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic done;
    logic [7:0] rdata;
  } fci_en_t;

  fci_en_t s_reg;
  fci_en_t s_next;

  // ==========================================================================
  // cycle sequencing
  // ==========================================================================
  // address and data stand from setup to hold, so the flash takes the address on
  // the last falling edge and the data on the first rising edge of its strobes
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      EN_IDLE:
        if (cyc.req)
        begin
          s_next.st = EN_SETUP;
          s_next.wr = cyc.wr;
          s_next.addr = cyc.addr;
          s_next.dq = cyc.wdata;
          s_next.dq_oe = cyc.wr;
          s_next.sel_n = 1'b0;
        end
      EN_SETUP:
      begin
        s_next.st = EN_STROBE;
        s_next.cnt = 4'(fci_pkg::STROBE_CYC - 1);
        s_next.we_n = ~s_reg.wr;
        s_next.oe_n = s_reg.wr;
      end
      EN_STROBE:
        if (s_reg.cnt == 4'h0)
        begin
          s_next.st = EN_HOLD;
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1;
          if (!s_reg.wr)
            s_next.rdata = dq_i; // sampled at the end of the output strobe
        end
        else
          s_next.cnt = s_reg.cnt - 4'h1;
      EN_HOLD:
      begin
        s_next.st = EN_IDLE;
        s_next.sel_n = 1'b1;
        s_next.dq_oe = 1'b0;
        s_next.done = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_reg <= '{st: EN_IDLE, wr: 1'b0, cnt: 4'h0, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                 addr: 20'h0_0000, dq: 8'h00, dq_oe: 1'b0, done: 1'b0, rdata: 8'h00};
    end
    else
      s_reg <= s_next;
  end

  assign flash_select_n = s_reg.sel_n;
  assign oe_n = s_reg.oe_n;
  assign we_n = s_reg.we_n;
  assign addr = s_reg.addr;
  assign dq_o = s_reg.dq;
  assign dq_oe = s_reg.dq_oe;
  assign cyc.done = s_reg.done;
  assign cyc.rdata = s_reg.rdata;

endmodule // fci_bus_engine

// File: fci_host_chk.sv
// checker of the flash pin cycles and apb answer of fci_host
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/1ps
module fci_host_chk
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic flash_select_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic dq_oe,
  input wire logic [19:0] flash_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // flash cycle shape and apb answer
  // ==========================================================================
  a_we_width: assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe not two cycles");
  a_sel_frame: assert property ($fell(flash_select_n) |->
    !flash_select_n[*4] ##1 flash_select_n)
    else $error("select frame not four cycles");
  a_we_in_sel: assert property (!we_n |-> !flash_select_n && oe_n)
    else $error("write strobe outside select");
  a_drive_write: assert property (!we_n |-> dq_oe)
    else $error("data not driven during write");
  a_no_drive_read: assert property (!oe_n |-> !dq_oe)
    else $error("bus fight during read");
  a_addr_held: assert property (!flash_select_n && !$past(flash_select_n) |->
    $stable(flash_addr))
    else $error("address moved inside cycle");
  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  cover property ($fell(we_n));
  cover property ($fell(oe_n));
  cover property (psel && pready);
endmodule // fci_host_chk

bind fci_host fci_host_chk fci_host_chk_inst (.*);

// File: fci_flash_model.sv
// behavioural flash: unlock, signature, program, chip erase, read/reset
// clockless; acts on the rising write strobe, where data is taken
`timescale 1ns/1ps
module fci_flash_model
#(
  parameter logic [7:0] MAN = 8'h00, // arbitrary code
  parameter logic [7:0] DEV = 8'h00, // arbitrary code
  parameter int BUSY_NS = 4000
)
(
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] a,
  input wire logic [7:0] d,
  output logic [7:0] q,
  output logic busy_n
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  logic [7:0] v;
  int c = 0;
  int k;
  bit sig = 0;
  bit tog = 0;
  bit ers = 0;
  initial busy_n = 1'b1;
  function automatic bit cod(int p);
    return (p == 0 && a == 20'h0_5555 && d == 8'haa) || (p == 1 && a == 20'h0_2aaa && d == 8'h55);
  endfunction
  // ==========================================================================
  // command decode; while busy only read/reset is taken, suspend is not modelled
  // ==========================================================================
  always @(posedge we_n)
    if (!sel_n && (busy_n || d == 8'hf0))
    begin
      k = c;
      c = 0;
      if (d == 8'hf0)
        {sig, busy_n} = 2'h1;
      else if (k != 7 && cod(k % 3))
        c = k + 1;
      else if (k == 2 && a == 20'h0_5555 && d == 8'h90)
        sig = 1;
      else if (k == 2 && a == 20'h0_5555 && d == 8'h80)
        c = 3;
      else if (k == 2 && a == 20'h0_5555 && d == 8'ha0)
        c = 7;
      else if (k == 7 || (k == 5 && a == 20'h0_5555 && d == 8'h10))
      begin
        if (k == 7)
          mem[a] = (mem.exists(a) ? mem[a] : 8'hff) & d;
        else
          mem.delete();
        {busy_n, ers} = {1'b0, k != 7};
        busy_n <= #(BUSY_NS) 1'b1;
      end
    end
  // reads: status while busy, else signature or array; released bus shows ~last
  always @(negedge oe_n)
    if (!busy_n)
      tog = ~tog;
  always @(a or sig or busy_n or tog or oe_n or sel_n)
  begin
    v = !busy_n ? {1'b0, tog, 2'h0, ers, 3'h0} : sig ? (a[0] ? DEV : MAN) :
      mem.exists(a) ? mem[a] : 8'hff;
    q = (!sel_n && !oe_n) ? v : ~last;
  end
  always @(posedge oe_n)
    last = v;
endmodule // fci_flash_model

// File: fci_host_tb.sv
// self-checking bench of fci_host with a behavioural flash on its pins
// assumes fci_pkg compiled first; 20 mhz clock, async active-low reset
`timescale 1ns/1ps
module fci_host_tb;
  localparam logic [7:0] MAN = 8'h5c; // arbitrary code
  localparam logic [7:0] DEV = 8'h3e; // arbitrary code
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, flash_select_n, oe_n, we_n;
  logic dq_oe, flash_reset_n, ready_busy_n, er;
  logic [7:0] paddr, dq_o, dq_i;
  logic [19:0] flash_addr;
  logic [31:0] pwdata, prdata, rd;
  int failures = 0;
  int n_checks = 0;
  fci_host fci_host_inst (.*);
  fci_flash_model #(.MAN(MAN), .DEV(DEV)) fci_flash_model_inst (.sel_n(flash_select_n),
    .oe_n(oe_n), .we_n(we_n), .a(flash_addr), .d(dq_o), .q(dq_i), .busy_n(ready_busy_n));
  // ==========================================================================
  // bus and compare tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
      @(posedge clk);
    while (pready !== 1'b1 && i++ < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50)
      summarize_hang();
  endtask
  task automatic summarize_hang;
    failures++;
    summarize();
  endtask
  task automatic setup(input logic [19:0] ad, input logic [7:0] d);
    apb(1'b1, fci_pkg::REG_ADDR, {12'h000, ad});
    apb(1'b1, fci_pkg::REG_WDATA, {24'h00_0000, d});
  endtask
  // status polled until idle; no poll timeout in the host, so bound it here
  task automatic run(input logic [3:0] op);
    int i;
    apb(1'b1, fci_pkg::REG_CTRL, {28'h000_0000, op});
    i = 0;
    do
      apb(1'b0, fci_pkg::REG_STATUS, 32'h0000_0000);
    while (rd[fci_pkg::ST_BUSY] !== 1'b0 && i++ < 2000);
    if (i >= 2000)
      summarize_hang();
  endtask
  task automatic readb(input logic [19:0] ad, input logic [7:0] e, input string nm);
    setup(ad, 8'h00);
    run(fci_pkg::OP_READ);
    chk(nm, e, rd[15:8]);
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset;
    apb(1'b0, fci_pkg::REG_STATUS, 32'h0000_0000);
    chk("status at reset", 8'h10, rd[7:0] & 8'h3f);
    apb(1'b0, fci_pkg::REG_PIN, 32'h0000_0000);
    chk("reset pin", 8'h01, rd[7:0] & 8'h01);
    chk("reset out", 8'h01, {7'h00, flash_reset_n});
  endtask
  task automatic t_sig;
    setup(20'h0_0000, 8'h00);
    run(fci_pkg::OP_SIGNATURE);
    chk("maker code", MAN, rd[15:8]);
    setup(20'h8_0001, 8'h00);
    run(fci_pkg::OP_SIGNATURE);
    chk("device code", DEV, rd[15:8]);
    run(fci_pkg::OP_RESET);
    readb(20'h8_0001, 8'hff, "array after reset");
  endtask
  task automatic t_prog;
    setup(20'h1_2345, 8'h5a);
    run(fci_pkg::OP_PROGRAM);
    chk("program done", 8'h02, rd[7:0] & 8'h07);
    readb(20'h1_2345, 8'h5a, "programmed byte");
    setup(20'h1_2345, 8'ha5);
    run(fci_pkg::OP_PROGRAM);
    readb(20'h1_2345, 8'h00, "bits only cleared");
  endtask
  task automatic t_erase;
    int i;
    apb(1'b1, fci_pkg::REG_CTRL, {28'h000_0000, fci_pkg::OP_CHIP_ERASE});
    i = 0;
    do
      apb(1'b0, fci_pkg::REG_STATUS, 32'h0000_0000);
    while (rd[fci_pkg::ST_RDY] !== 1'b0 && i++ < 100);
    chk("busy while erasing", 8'h01, rd[7:0] & 8'h11);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 8'h01, {7'h00, er});
    run(fci_pkg::OP_WAIT);
    chk("reject busy", 8'h20, rd[7:0] & 8'h20);
    readb(20'h1_2345, 8'hff, "erased byte");
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_sig();
    t_prog();
    t_erase();
    summarize();
  end
endmodule // fci_host_tb
